// >>> rtl/smpb_pkg.sv
/*
 Constants, register indices, limits and reset values of the second-motor parameter bank.
 Assumes a single 10 MHz clock domain and a word-wide AHB-Lite register bus.
*/
// Summary of operation
// - Frequency source accepts 0,1,2,3,4,6,7,10 only.
// - Command source accepts codes 1 through 4.
// - Maximum 300..4000; base 300..current maximum.
// - Multispeed 32-bit, high first, zero or start..maximum.
// - Boost method 0 manual, 1 automatic.
// - Curve select 0..3; higher codes refused.
// - Boost 20..200, gain 20..100, boost frequency 0..255.
// - Regulation mode 0 on, 1 off, 2 off decelerating.
// - Low class codes 0..4 give 200..240 volts.
// - High class codes 5..10 give 380..480 volts.
// - Lower limit 32-bit, zero or start..maximum.
// - Upper limit 32-bit, zero or lower..maximum.
package smpb_pkg;

	// ==========================================================
	// Register indices; byte address is four times the index.
	localparam logic [15:0] IDX_ACCEL_HI = 16'h2103;
	localparam logic [15:0] IDX_ACCEL_LO = 16'h2104;
	localparam logic [15:0] IDX_DECEL_HI = 16'h2105;
	localparam logic [15:0] IDX_DECEL_LO = 16'h2106;
	localparam logic [15:0] IDX_FSRC = 16'h2201;
	localparam logic [15:0] IDX_CSRC = 16'h2202;
	localparam logic [15:0] IDX_BASE = 16'h2203;
	localparam logic [15:0] IDX_MAXF = 16'h2204;
	localparam logic [15:0] IDX_MSPD_HI = 16'h2216;
	localparam logic [15:0] IDX_MSPD_LO = 16'h2217;
	localparam logic [15:0] IDX_BMETH = 16'h223B;
	localparam logic [15:0] IDX_MBOOST = 16'h223C;
	localparam logic [15:0] IDX_MBFREQ = 16'h223D;
	localparam logic [15:0] IDX_VFSEL = 16'h223E;
	localparam logic [15:0] IDX_VFGAIN = 16'h223F;
	localparam logic [15:0] IDX_AVGAIN = 16'h2240;
	localparam logic [15:0] IDX_SLGAIN = 16'h2241;
	localparam logic [15:0] IDX_UPPER_HI = 16'h224F;
	localparam logic [15:0] IDX_UPPER_LO = 16'h2250;
	localparam logic [15:0] IDX_LOWER_HI = 16'h2251;
	localparam logic [15:0] IDX_LOWER_LO = 16'h2252;
	localparam logic [15:0] IDX_AVRMODE = 16'h2269;
	localparam logic [15:0] IDX_AVRLEVEL = 16'h226A;
	localparam logic [15:0] IDX_STATUS = 16'h2000;

	// ==========================================================
	// Status bits, write one to clear.
	localparam int ST_REJECTED_BIT = 0;
	localparam int ST_UNMAPPED_BIT = 1;

	// ==========================================================
	// Value limits.
	localparam logic [31:0] RAMP_MIN = 32'h00000001;
	localparam logic [31:0] RAMP_MAX = 32'h00057E40;
	localparam logic [31:0] MAXF_MIN = 32'h0000012C;
	localparam logic [31:0] MAXF_MAX = 32'h00000FA0;
	localparam logic [31:0] BOOST_MIN = 32'h00000014;
	localparam logic [31:0] BOOST_MAX = 32'h000000C8;
	localparam logic [31:0] GAIN_MIN = 32'h00000014;
	localparam logic [31:0] GAIN_MAX = 32'h00000064;
	localparam logic [31:0] BYTE_MAX = 32'h000000FF;
	localparam logic [31:0] METH_MAX = 32'h00000001;
	localparam logic [31:0] CURVE_MAX = 32'h00000003;
	localparam logic [31:0] CSRC_MIN = 32'h00000001;
	localparam logic [31:0] CSRC_MAX = 32'h00000004;
	localparam logic [31:0] AVR_MODE_MAX = 32'h00000002;
	localparam logic [31:0] LVL_LOW_MAX = 32'h00000004;
	localparam logic [31:0] LVL_HIGH_MIN = 32'h00000005;
	localparam logic [31:0] LVL_HIGH_MAX = 32'h0000000A;
	// Maximum frequency is in 0.1 Hz, pair values in 0.01 Hz.
	localparam logic [31:0] FREQ_SCALE = 32'h0000000A;
	// Frequency source codes that are not accepted between 0 and 10, then the last accepted code.
	localparam logic [15:0] FSRC_GAP_A = 16'h0005;
	localparam logic [15:0] FSRC_GAP_B = 16'h0008;
	localparam logic [15:0] FSRC_GAP_C = 16'h0009;
	localparam logic [15:0] FSRC_LAST = 16'h000A;

	// ==========================================================
	// Reset values.
	localparam logic [31:0] RST_RAMP = 32'h000003E8;
	localparam logic [15:0] RST_FSRC = 16'h0002;
	localparam logic [15:0] RST_CSRC = 16'h0002;
	localparam logic [15:0] RST_FREQ = 16'h0258;
	localparam logic [15:0] RST_BOOST = 16'h0014;
	localparam logic [15:0] RST_GAIN = 16'h0064;
	localparam logic [15:0] RST_ZERO = 16'h0000;

	typedef enum logic {
		SMPB_IDLE = 1'b0,
		SMPB_DATA = 1'b1
	} smpb_bus_state_t;

endpackage

// >>> rtl/smpb_sync.sv
/*
 Three-stage synchroniser for one level from a pin.
 Assumes the level is slow; a change is taken once stages two and three agree.
*/
`timescale 1ns/100ps
module smpb_sync (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic pin,
	output logic level
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} smpb_sync_t;

	smpb_sync_t r;
	smpb_sync_t next_r;

	// ==========================================================
	// Stage chain.
	always_comb begin
		next_r = r;
		if (clk_en) begin
			next_r.s1 = pin;
			next_r.s2 = r.s1;
			next_r.s3 = r.s2;
			if (r.s2 == r.s3) begin
				next_r.q = r.s3;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign level = r.q;

endmodule

// >>> rtl/smpb_avr_decode.sv
/*
 Turns the regulation voltage code into volts for the drive's class.
 Assumes the code was range-checked on write; a code outside the class gives zero.
*/
`timescale 1ns/100ps
module smpb_avr_decode (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic high_class,
	input wire logic [15:0] code,
	output logic [15:0] volts
);

	typedef struct packed {
		logic [15:0] volts;
	} smpb_avr_t;

	smpb_avr_t r;
	smpb_avr_t next_r;

	always_comb begin
		next_r = r;
		if (clk_en) begin
			next_r.volts = 16'h0000;
			if (!high_class) begin
				case (code)
					16'h0000: next_r.volts = 16'h00C8;
					16'h0001: next_r.volts = 16'h00D7;
					16'h0002: next_r.volts = 16'h00DC;
					16'h0003: next_r.volts = 16'h00E6;
					16'h0004: next_r.volts = 16'h00F0;
					default: next_r.volts = 16'h0000;
				endcase
			end else begin
				case (code)
					16'h0005: next_r.volts = 16'h017C;
					16'h0006: next_r.volts = 16'h0190;
					16'h0007: next_r.volts = 16'h019F;
					16'h0008: next_r.volts = 16'h01B8;
					16'h0009: next_r.volts = 16'h01CC;
					16'h000A: next_r.volts = 16'h01E0;
					default: next_r.volts = 16'h0000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign volts = r.volts;

endmodule

// >>> rtl/smpb_bank.sv
/*
 Second-motor parameter bank: range-checked 16-bit and paired 32-bit registers behind an AHB-Lite slave.
 Assumes one clock, word transfers, and a start frequency given by the drive core.
*/
`timescale 1ns/100ps
module smpb_bank (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic voltage_class_pin,
	input wire logic [15:0] start_frequency,
	output logic [31:0] accel_time_one,
	output logic [31:0] decel_time_one,
	output logic [15:0] frequency_source_select,
	output logic [15:0] command_source_select,
	output logic [15:0] base_frequency,
	output logic [15:0] maximum_frequency,
	output logic [31:0] multispeed_frequency,
	output logic [15:0] boost_method_select,
	output logic [15:0] volt_freq_curve_select,
	output logic [31:0] upper_frequency_limit,
	output logic [31:0] lower_frequency_limit,
	output logic [15:0] voltage_regulation_mode,
	output logic [15:0] regulation_volts
);

	typedef struct packed {
		smpb_pkg::smpb_bus_state_t state;
		logic [15:0] idx;
		logic wr;
		logic bad;
		logic rdy;
		logic [31:0] rdata;
		logic [15:0] stage_hi;
		logic rejected;
		logic unmapped;
		logic [31:0] accel;
		logic [31:0] decel;
		logic [31:0] mspd;
		logic [31:0] upper;
		logic [31:0] lower;
		logic [15:0] fsrc;
		logic [15:0] csrc;
		logic [15:0] base;
		logic [15:0] maxf;
		logic [15:0] bmeth;
		logic [15:0] mboost;
		logic [15:0] mbfreq;
		logic [15:0] vfsel;
		logic [15:0] vfgain;
		logic [15:0] avgain;
		logic [15:0] slgain;
		logic [15:0] avrmode;
		logic [15:0] avrlevel;
	} smpb_bank_t;

	smpb_bank_t r;
	smpb_bank_t next_r;
	logic high_class;
	logic [31:0] v16;
	logic [31:0] v32;
	logic [31:0] top_hz;
	logic [31:0] start_hz;
	logic upper_ok;
	logic wide_ok;
	logic hit;
	logic ok;

	// ==========================================================
	// Range helpers.
	function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	function automatic logic zero_or_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		return (v == 32'h00000000) || in_range(v, lo, hi);
	endfunction

	function automatic logic fsrc_ok(input logic [15:0] c);
		return (c <= smpb_pkg::FSRC_LAST) && (c != smpb_pkg::FSRC_GAP_A) &&
			(c != smpb_pkg::FSRC_GAP_B) && (c != smpb_pkg::FSRC_GAP_C);
	endfunction

	function automatic logic [31:0] low_of(input logic [31:0] v);
		return {16'h0000, v[15:0]};
	endfunction

	function automatic logic [31:0] high_of(input logic [31:0] v);
		return {16'h0000, v[31:16]};
	endfunction

	// ==========================================================
	// Supporting blocks.
	smpb_sync u_class_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(clk_en),
		.pin(voltage_class_pin),
		.level(high_class)
	);

	smpb_avr_decode u_avr (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(clk_en),
		.high_class(high_class),
		.code(r.avrlevel),
		.volts(regulation_volts)
	);

	// ==========================================================
	// Bus transfers and register updates.
	always_comb begin
		next_r = r;
		v16 = {16'h0000, hwdata[15:0]};
		v32 = {r.stage_hi, hwdata[15:0]};
		top_hz = 32'(r.maxf) * smpb_pkg::FREQ_SCALE;
		start_hz = {16'h0000, start_frequency};
		wide_ok = (hwdata[31:16] == 16'h0000);
		// An upper limit of zero leaves the lower limit at its own floor.
		upper_ok = (v32 == 32'h00000000) || in_range(v32, r.lower, top_hz);
		hit = 1'b1;
		ok = 1'b1;
		if (clk_en) begin
			case (r.state)
				smpb_pkg::SMPB_IDLE: begin
					if (hsel && htrans[1] && hready) begin
						next_r.state = smpb_pkg::SMPB_DATA;
						next_r.rdy = 1'b0;
						next_r.wr = hwrite;
						next_r.idx = haddr[17:2];
						next_r.bad = (haddr[31:18] != 14'h0000) || (haddr[1:0] != 2'h0) || (hsize != 3'h2);
					end
				end
				smpb_pkg::SMPB_DATA: begin
					next_r.state = smpb_pkg::SMPB_IDLE;
					next_r.rdy = 1'b1;
					next_r.rdata = 32'h00000000;
					if (r.bad) begin
						hit = 1'b0;
					end else begin
						case (r.idx)
							// ramp times, multispeed and limits staged high then checked whole
							smpb_pkg::IDX_ACCEL_HI, smpb_pkg::IDX_DECEL_HI, smpb_pkg::IDX_MSPD_HI,
							smpb_pkg::IDX_UPPER_HI, smpb_pkg::IDX_LOWER_HI: begin
								ok = wide_ok;
								if (r.wr && ok) begin
									next_r.stage_hi = hwdata[15:0];
								end
								case (r.idx)
									smpb_pkg::IDX_ACCEL_HI: next_r.rdata = high_of(r.accel);
									smpb_pkg::IDX_DECEL_HI: next_r.rdata = high_of(r.decel);
									smpb_pkg::IDX_MSPD_HI: next_r.rdata = high_of(r.mspd);
									smpb_pkg::IDX_UPPER_HI: next_r.rdata = high_of(r.upper);
									default: next_r.rdata = high_of(r.lower);
								endcase
							end
							smpb_pkg::IDX_ACCEL_LO: begin
								next_r.rdata = low_of(r.accel);
								ok = wide_ok && in_range(v32, smpb_pkg::RAMP_MIN, smpb_pkg::RAMP_MAX);
								if (r.wr && ok) begin
									next_r.accel = v32;
								end
							end
							smpb_pkg::IDX_DECEL_LO: begin
								next_r.rdata = low_of(r.decel);
								ok = wide_ok && in_range(v32, smpb_pkg::RAMP_MIN, smpb_pkg::RAMP_MAX);
								if (r.wr && ok) begin
									next_r.decel = v32;
								end
							end
							smpb_pkg::IDX_FSRC: begin
								next_r.rdata = {16'h0000, r.fsrc};
								ok = wide_ok && fsrc_ok(hwdata[15:0]);
								if (r.wr && ok) begin
									next_r.fsrc = hwdata[15:0];
								end
							end
							smpb_pkg::IDX_CSRC: begin
								next_r.rdata = {16'h0000, r.csrc};
								ok = wide_ok && in_range(v16, smpb_pkg::CSRC_MIN, smpb_pkg::CSRC_MAX);
								if (r.wr && ok) begin
									next_r.csrc = hwdata[15:0];
								end
							end
							smpb_pkg::IDX_BASE: begin
								next_r.rdata = {16'h0000, r.base};
								ok = wide_ok && in_range(v16, smpb_pkg::MAXF_MIN, {16'h0000, r.maxf});
								if (r.wr && ok) begin
									next_r.base = hwdata[15:0];
								end
							end
							smpb_pkg::IDX_MAXF: begin
								next_r.rdata = {16'h0000, r.maxf};
								ok = wide_ok && in_range(v16, smpb_pkg::MAXF_MIN, smpb_pkg::MAXF_MAX);
								if (r.wr && ok) begin
									next_r.maxf = hwdata[15:0];
								end
							end
							smpb_pkg::IDX_MSPD_LO: begin
								next_r.rdata = low_of(r.mspd);
								ok = wide_ok && zero_or_range(v32, start_hz, top_hz);
								if (r.wr && ok) begin
									next_r.mspd = v32;
								end
							end
							smpb_pkg::IDX_BMETH: begin
								next_r.rdata = {16'h0000, r.bmeth};
								ok = wide_ok && (v16 <= smpb_pkg::METH_MAX);
								if (r.wr && ok) begin
									next_r.bmeth = hwdata[15:0];
								end
							end
							smpb_pkg::IDX_MBOOST: begin
								next_r.rdata = {16'h0000, r.mboost};
								ok = wide_ok && in_range(v16, smpb_pkg::BOOST_MIN, smpb_pkg::BOOST_MAX);
								if (r.wr && ok) begin
									next_r.mboost = hwdata[15:0];
								end
							end
							smpb_pkg::IDX_MBFREQ: begin
								next_r.rdata = {16'h0000, r.mbfreq};
								ok = wide_ok && (v16 <= smpb_pkg::BYTE_MAX);
								if (r.wr && ok) begin
									next_r.mbfreq = hwdata[15:0];
								end
							end
							smpb_pkg::IDX_VFSEL: begin
								next_r.rdata = {16'h0000, r.vfsel};
								ok = wide_ok && (v16 <= smpb_pkg::CURVE_MAX);
								if (r.wr && ok) begin
									next_r.vfsel = hwdata[15:0];
								end
							end
							smpb_pkg::IDX_VFGAIN: begin
								next_r.rdata = {16'h0000, r.vfgain};
								ok = wide_ok && in_range(v16, smpb_pkg::GAIN_MIN, smpb_pkg::GAIN_MAX);
								if (r.wr && ok) begin
									next_r.vfgain = hwdata[15:0];
								end
							end
							smpb_pkg::IDX_AVGAIN: begin
								next_r.rdata = {16'h0000, r.avgain};
								ok = wide_ok && (v16 <= smpb_pkg::BYTE_MAX);
								if (r.wr && ok) begin
									next_r.avgain = hwdata[15:0];
								end
							end
							smpb_pkg::IDX_SLGAIN: begin
								next_r.rdata = {16'h0000, r.slgain};
								ok = wide_ok && (v16 <= smpb_pkg::BYTE_MAX);
								if (r.wr && ok) begin
									next_r.slgain = hwdata[15:0];
								end
							end
							smpb_pkg::IDX_UPPER_LO: begin
								next_r.rdata = low_of(r.upper);
								ok = wide_ok && upper_ok;
								if (r.wr && ok) begin
									next_r.upper = v32;
								end
							end
							smpb_pkg::IDX_LOWER_LO: begin
								next_r.rdata = low_of(r.lower);
								ok = wide_ok && zero_or_range(v32, start_hz, top_hz);
								if (r.wr && ok) begin
									next_r.lower = v32;
								end
							end
							smpb_pkg::IDX_AVRMODE: begin
								next_r.rdata = {16'h0000, r.avrmode};
								ok = wide_ok && (v16 <= smpb_pkg::AVR_MODE_MAX);
								if (r.wr && ok) begin
									next_r.avrmode = hwdata[15:0];
								end
							end
							// level codes follow the drive class
							smpb_pkg::IDX_AVRLEVEL: begin
								next_r.rdata = {16'h0000, r.avrlevel};
								ok = wide_ok && (high_class ?
									in_range(v16, smpb_pkg::LVL_HIGH_MIN, smpb_pkg::LVL_HIGH_MAX) :
									(v16 <= smpb_pkg::LVL_LOW_MAX));
								if (r.wr && ok) begin
									next_r.avrlevel = hwdata[15:0];
								end
							end
							smpb_pkg::IDX_STATUS: begin
								next_r.rdata = {30'h0, r.unmapped, r.rejected};
								if (r.wr) begin
									next_r.rejected = r.rejected & ~hwdata[smpb_pkg::ST_REJECTED_BIT];
									next_r.unmapped = r.unmapped & ~hwdata[smpb_pkg::ST_UNMAPPED_BIT];
								end
							end
							default: begin
								hit = 1'b0;
							end
						endcase
					end
					// refused access sets a sticky flag
					if (!hit) begin
						next_r.unmapped = 1'b1;
					end else if (r.wr && !ok) begin
						next_r.rejected = 1'b1;
					end
				end
				default: begin
					next_r.state = smpb_pkg::SMPB_IDLE;
					next_r.rdy = 1'b1;
				end
			endcase
		end
	end

	// ==========================================================
	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '{state: smpb_pkg::SMPB_IDLE, idx: 16'h0000, wr: 1'b0, bad: 1'b0, rdy: 1'b1,
				rdata: 32'h00000000, stage_hi: 16'h0000, rejected: 1'b0, unmapped: 1'b0,
				accel: smpb_pkg::RST_RAMP, decel: smpb_pkg::RST_RAMP, mspd: 32'h00000000,
				upper: 32'h00000000, lower: 32'h00000000, fsrc: smpb_pkg::RST_FSRC,
				csrc: smpb_pkg::RST_CSRC, base: smpb_pkg::RST_FREQ, maxf: smpb_pkg::RST_FREQ,
				bmeth: smpb_pkg::RST_ZERO, mboost: smpb_pkg::RST_BOOST, mbfreq: smpb_pkg::RST_ZERO,
				vfsel: smpb_pkg::RST_ZERO, vfgain: smpb_pkg::RST_GAIN, avgain: smpb_pkg::RST_ZERO,
				slgain: smpb_pkg::RST_ZERO, avrmode: smpb_pkg::RST_ZERO, avrlevel: smpb_pkg::RST_ZERO};
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// Outputs. The bus answer is always OKAY; refusals show in the status word only.
	assign hrdata = r.rdata;
	assign hreadyout = r.rdy;
	assign hresp = 1'b0;
	assign accel_time_one = r.accel;
	assign decel_time_one = r.decel;
	assign frequency_source_select = r.fsrc;
	assign command_source_select = r.csrc;
	assign base_frequency = r.base;
	assign maximum_frequency = r.maxf;
	assign multispeed_frequency = r.mspd;
	assign boost_method_select = r.bmeth;
	assign volt_freq_curve_select = r.vfsel;
	assign upper_frequency_limit = r.upper;
	assign lower_frequency_limit = r.lower;
	assign voltage_regulation_mode = r.avrmode;

endmodule

// >>> tb/smpb_bank_chk.sv
/*
 Concurrent checks on the parameter bank ports, bound into every bank instance.
 Assumes one clock domain and the one-wait-state bus answer of the bank.
*/
`timescale 1ns/100ps
module smpb_bank_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [15:0] start_frequency,
	input wire logic [31:0] accel_time_one,
	input wire logic [15:0] frequency_source_select,
	input wire logic [15:0] command_source_select,
	input wire logic [15:0] base_frequency,
	input wire logic [15:0] maximum_frequency,
	input wire logic [31:0] multispeed_frequency,
	input wire logic [15:0] boost_method_select,
	input wire logic [15:0] volt_freq_curve_select,
	input wire logic [31:0] upper_frequency_limit,
	input wire logic [31:0] lower_frequency_limit,
	input wire logic [15:0] voltage_regulation_mode
);
	// ==========================================================
	// Assertions
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_HRESP_OKAY: assert property (hresp == 1'b0)
		else $error("hresp not OKAY");
	AST_ONE_WAIT: assert property (clk_en && hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
		else $error("wait state count wrong");
	AST_FSRC_CODES: assert property (frequency_source_select inside {[0:4], 6, 7, 10})
		else $error("frequency source code invalid");
	AST_CSRC_RANGE: assert property (command_source_select inside {[1:4]})
		else $error("command source code invalid");
	AST_MAXF_RANGE: assert property (maximum_frequency inside {[300:4000]})
		else $error("maximum frequency out of range");
	AST_BASE_BOUND: assert property ($changed(base_frequency) |-> base_frequency >= 16'h012C
		&& base_frequency <= $past(maximum_frequency))
		else $error("base frequency out of range");
	AST_CODES_SMALL: assert property (boost_method_select <= 16'h0001 && volt_freq_curve_select <= 16'h0003
		&& voltage_regulation_mode <= 16'h0002)
		else $error("mode code invalid");
	AST_RAMP_RANGE: assert property ($changed(accel_time_one) |-> accel_time_one >= smpb_pkg::RAMP_MIN
		&& accel_time_one <= smpb_pkg::RAMP_MAX)
		else $error("ramp time out of range");
	AST_MSPD_RANGE: assert property ($changed(multispeed_frequency) |-> multispeed_frequency == 32'h0 ||
		(multispeed_frequency >= $past(start_frequency) && multispeed_frequency <= $past(maximum_frequency) * 32'hA))
		else $error("multispeed out of range");
	AST_UPPER_RANGE: assert property ($changed(upper_frequency_limit) |-> upper_frequency_limit == 32'h0 ||
		upper_frequency_limit >= $past(lower_frequency_limit))
		else $error("upper limit below lower limit");
	cover property (hsel && htrans[1] && hready && !hreadyout);
	cover property ($changed(multispeed_frequency));
	cover property ($changed(voltage_regulation_mode));
endmodule
bind smpb_bank smpb_bank_chk chk (.*);

// >>> tb/smpb_master.sv
/*
 Bus master model: single word transfers on AHB-Lite, with paired 32-bit writes.
 Assumes hready is the slave's hreadyout; every wait is bounded and flags hung.
*/
`timescale 1ns/100ps
module smpb_master (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	output logic hung
);
	// ==========================================================
	// Transfers
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		hung = 1'b0;
	end
	task automatic wt;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 40);
		if (n >= 40) hung <= 1'b1;
	endtask
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {14'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		wt();
		htrans <= 2'b00;
		hwdata <= d;
		wt();
		r = hrdata;
	endtask
	task automatic pair(input logic [15:0] idx, input logic [31:0] v);
		logic [31:0] r;
		xfer(1'b1, idx, {16'h0, v[31:16]}, r);
		xfer(1'b1, idx + 16'h1, {16'h0, v[15:0]}, r);
	endtask
endmodule

// >>> tb/second_motor_parameter_bank_test.sv
/*
 Self-checking bench: scenario tasks drive the bank through the master model.
 Assumes refusals leave values unchanged and show in the status word.
*/
`timescale 1ns/100ps
module second_motor_parameter_bank_test;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hung, vpin;
	logic [31:0] haddr, hwdata, hrdata, acc, msp, dec;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] sfreq, volts;
	logic [15:0] lv [11] = '{16'hC8, 16'hD7, 16'hDC, 16'hE6, 16'hF0, 16'h17C, 16'h190, 16'h19F, 16'h1B8, 16'h1CC, 16'h1E0};
	int mismatches = 0;
	int cmp_count = 0;
	smpb_master m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung));
	smpb_bank dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .voltage_class_pin(vpin), .start_frequency(sfreq), .accel_time_one(acc), .decel_time_one(dec),
		.frequency_source_select(), .command_source_select(), .base_frequency(), .maximum_frequency(),
		.multispeed_frequency(msp), .boost_method_select(), .volt_freq_curve_select(), .upper_frequency_limit(),
		.lower_frequency_limit(), .voltage_regulation_mode(), .regulation_volts(volts));
	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		m.xfer(1'b0, idx, 32'h0, r);
		chk(r, exp);
	endtask
	task automatic wc(input logic [15:0] idx, input logic [31:0] d, input logic [31:0] exp);
		logic [31:0] r;
		m.xfer(1'b1, idx, d, r);
		rd(idx, exp);
	endtask
	task automatic sweep(input logic [15:0] idx, input int n, input logic [15:0] ok, input logic [31:0] e);
		for (int c = 0; c < n; c++) begin
			if (ok[c]) e = 32'(c);
			wc(idx, 32'(c), e);
		end
	endtask
	// ==========================================================
	// Scenarios
	// reset values
	task automatic s_reset;
		rd(smpb_pkg::IDX_FSRC, 32'h2);
		rd(smpb_pkg::IDX_CSRC, 32'h2);
		rd(smpb_pkg::IDX_MAXF, 32'h258);
		rd(smpb_pkg::IDX_ACCEL_LO, 32'h3E8);
		chk({16'h0, volts}, 32'hC8);
	endtask
	task automatic s_codes;
		sweep(smpb_pkg::IDX_FSRC, 12, 16'h04DF, 32'h2);
		sweep(smpb_pkg::IDX_CSRC, 6, 16'h001E, 32'h2);
		sweep(smpb_pkg::IDX_BMETH, 3, 16'h0003, 32'h0);
		sweep(smpb_pkg::IDX_VFSEL, 5, 16'h000F, 32'h0);
		sweep(smpb_pkg::IDX_AVRMODE, 4, 16'h0007, 32'h0);
	endtask
	task automatic s_limits;
		wc(smpb_pkg::IDX_MAXF, 32'hFA1, 32'h258);
		wc(smpb_pkg::IDX_MAXF, 32'hFA0, 32'hFA0);
		wc(smpb_pkg::IDX_MAXF, 32'h12B, 32'hFA0);
		wc(smpb_pkg::IDX_BASE, 32'hFA0, 32'hFA0);
		wc(smpb_pkg::IDX_BASE, 32'h12B, 32'hFA0);
		wc(smpb_pkg::IDX_MBOOST, 32'h13, 32'h14);
		wc(smpb_pkg::IDX_MBOOST, 32'hC9, 32'h14);
		wc(smpb_pkg::IDX_MBOOST, 32'hC8, 32'hC8);
		wc(smpb_pkg::IDX_VFGAIN, 32'h65, 32'h64);
		wc(smpb_pkg::IDX_VFGAIN, 32'h14, 32'h14);
		wc(smpb_pkg::IDX_MBFREQ, 32'hFF, 32'hFF);
		wc(smpb_pkg::IDX_MBFREQ, 32'h100, 32'hFF);
		wc(smpb_pkg::IDX_AVGAIN, 32'hFF, 32'hFF);
		wc(smpb_pkg::IDX_AVGAIN, 32'h100, 32'hFF);
		wc(smpb_pkg::IDX_SLGAIN, 32'h100, 32'h0);
		wc(smpb_pkg::IDX_SLGAIN, 32'hFF, 32'hFF);
	endtask
	task automatic s_pairs;
		m.pair(smpb_pkg::IDX_MSPD_HI, 32'h9C40);
		chk(msp, 32'h9C40);
		m.pair(smpb_pkg::IDX_MSPD_HI, 32'h31);
		m.pair(smpb_pkg::IDX_MSPD_HI, 32'h9C41);
		chk(msp, 32'h9C40);
		m.pair(smpb_pkg::IDX_ACCEL_HI, 32'h57E40);
		m.pair(smpb_pkg::IDX_ACCEL_HI, 32'h57E41);
		m.pair(smpb_pkg::IDX_ACCEL_HI, 32'h0);
		chk(acc, 32'h57E40);
		rd(smpb_pkg::IDX_ACCEL_HI, 32'h5);
		m.pair(smpb_pkg::IDX_DECEL_HI, 32'h1);
		chk(dec, 32'h1);
		rd(smpb_pkg::IDX_DECEL_LO, 32'h1);
		m.pair(smpb_pkg::IDX_LOWER_HI, 32'h64);
		rd(smpb_pkg::IDX_LOWER_LO, 32'h64);
		m.pair(smpb_pkg::IDX_UPPER_HI, 32'h63);
		rd(smpb_pkg::IDX_UPPER_LO, 32'h0);
		m.pair(smpb_pkg::IDX_UPPER_HI, 32'h64);
		rd(smpb_pkg::IDX_UPPER_LO, 32'h64);
	endtask
	task automatic s_volts;
		for (int c = 0; c < 11; c++) begin
			if (c == 5) begin
				wc(smpb_pkg::IDX_AVRLEVEL, 32'h5, 32'h4);
				vpin <= 1'b1;
				repeat (8) @(posedge hclk);
			end
			wc(smpb_pkg::IDX_AVRLEVEL, 32'(c), 32'(c));
			chk({16'h0, volts}, {16'h0, lv[c]});
		end
		wc(smpb_pkg::IDX_AVRLEVEL, 32'h4, 32'hA);
	endtask
	task automatic s_refuse;
		logic [31:0] r;
		wc(smpb_pkg::IDX_STATUS, 32'h3, 32'h0);
		m.hsize <= 3'b001;
		m.xfer(1'b1, smpb_pkg::IDX_FSRC, 32'h3, r);
		m.hsize <= 3'b010;
		rd(smpb_pkg::IDX_FSRC, 32'hA);
		rd(smpb_pkg::IDX_STATUS, 32'h2);
		wc(smpb_pkg::IDX_STATUS, 32'h3, 32'h0);
		wc(16'h2107, 32'h1234, 32'h0);
		rd(smpb_pkg::IDX_STATUS, 32'h2);
		wc(smpb_pkg::IDX_FSRC, 32'h10003, 32'hA);
		rd(smpb_pkg::IDX_STATUS, 32'h3);
	endtask
	// ==========================================================
	// Run control
	task automatic tally_and_finish;
		if (hung) mismatches++;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge hung) begin
		tally_and_finish();
	end
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	initial begin
		hresetn = 1'b0;
		vpin = 1'b0;
		sfreq = 16'h0032;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		s_reset();
		s_codes();
		s_limits();
		s_pairs();
		s_volts();
		s_refuse();
		tally_and_finish();
	end
endmodule
